// file: dpse_map.svh
`ifndef DPSE_MAP_SVH
`define DPSE_MAP_SVH

// ----------------------------------------------------------------------------
// command word layout (24 bits, most significant bit first on the wire)
// ----------------------------------------------------------------------------
`define DPSE_WORD_BITS      24
`define DPSE_OPCODE_HI      23
`define DPSE_OPCODE_LO      20
`define DPSE_PSEL_HI        19
`define DPSE_PSEL_LO        18
`define DPSE_CHAN_HI        17
`define DPSE_CHAN_LO        16
`define DPSE_BUF_MODE_POS   8
`define DPSE_DATA_HI        7
`define DPSE_DATA_LO        0

// ----------------------------------------------------------------------------
// values
// ----------------------------------------------------------------------------
`define DPSE_CHAN_ONLY      2'h0
`define DPSE_WIPER_MAX      8'hFF
`define DPSE_WIPER_MIN      8'h00
`define DPSE_PRESET_INIT    9'h080
`define DPSE_PRESET_ERASED  9'h1FF
`define DPSE_READ_PAD       15'h0000
`define DPSE_BOOT_PRESET    2'h0

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define DPSE_CLK_HZ         50000000
`define DPSE_NV_SAVE_WAIT_MS 2
`define DPSE_NV_WAIT_CYC    (`DPSE_NV_SAVE_WAIT_MS * (`DPSE_CLK_HZ / 1000))

`endif

// file: dpse_pkg.sv
package dpse_pkg;

  // main control states, one-hot
  typedef enum logic [4:0] {
    ST_BOOT   = 5'h01,
    ST_BOOTLD = 5'h02,
    ST_SLEEP  = 5'h04,
    ST_AWAKE  = 5'h08,
    ST_NVWAIT = 5'h10
  } dpse_state_type;

  // opcode_field encodings
  typedef enum logic [3:0] {
    OP_NOP        = 4'h0,
    OP_WAKE       = 4'h1,
    OP_PROG       = 4'h2,
    OP_STORE      = 4'h3,
    OP_WRITE      = 4'h4,
    OP_UP         = 4'h7,
    OP_SLEEP      = 4'h8,
    OP_SWRESET    = 4'h9,
    OP_RD_PRESET  = 4'hA,
    OP_LOAD       = 4'hB,
    OP_RD_WIPER   = 4'hC,
    OP_ERASE      = 4'hD,
    OP_DOWN       = 4'hF
  } dpse_opcode_type;

  // what the cycle after an accepted command does with preset read data
  typedef enum logic [1:0] {
    PEND_NONE = 2'h0,
    PEND_READ = 2'h1,
    PEND_LOAD = 2'h2
  } dpse_pend_type;

endpackage

// file: dpse_preset_mem.sv
`include "dpse_map.svh"

// four 9-bit preset words with a registered read port
module dpse_preset_mem (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] rd_addr,
  output logic      [8:0] rd_data,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_addr,
  input  wire logic [8:0] wr_data
);

  logic [8:0] word_ff [4];

  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  // reset stands for power-up contents; software reset never reaches here
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        word_ff[i] <= `DPSE_PRESET_INIT;
      end
    end else if (wr_en) begin
      word_ff[wr_addr] <= wr_data;
    end
  end

  // ---------------------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= `DPSE_PRESET_INIT;
    end else begin
      rd_data <= word_ff[rd_addr];
    end
  end

endmodule

// file: dpse_engine.sv
`include "dpse_map.svh"

module dpse_engine #(
  parameter int NV_WAIT_CYC = `DPSE_NV_WAIT_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       SCLK,
  input  wire logic       CS_N,
  input  wire logic       SERIAL_IN,
  input  wire logic       WP_N,
  output logic            SERIAL_OUT,
  output logic            SERIAL_OUT_OE,
  output logic      [7:0] WIPER_SETTING,
  output logic            BUFFER_MODE,
  output logic            LOGIC_CLK_EN,
  output logic            NV_BUSY
);

  // ---------------------------------------------------------------------------
  // link side: serial clock domain
  // ---------------------------------------------------------------------------
  logic [4:0]  bit_cnt_ff;
  logic [22:0] rx_sh_ff;
  logic [23:0] cmd_word_ff;
  logic        word_done_ff;
  logic [23:0] tx_word_ff;
  logic        sdo_ff;
  logic [4:0]  tx_idx;

  // main side state, read quasi-statically by the link at frame start
  logic        rd_valid_ff;
  logic [8:0]  rd_word_ff;

  // bit counter: chip select high holds it clear between frames
  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      bit_cnt_ff <= 5'h00;
    end else if (bit_cnt_ff != 5'(`DPSE_WORD_BITS)) begin
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
  end

  // input shift on rising edges, msb first; extra clocks past 24 are ignored
  always_ff @(posedge SCLK) begin
    if (!CS_N && bit_cnt_ff < 5'(`DPSE_WORD_BITS - 1)) begin
      rx_sh_ff <= {rx_sh_ff[21:0], SERIAL_IN};
    end
  end

  // the 24th rising edge completes a word; the first edge of a frame
  // withdraws the flag, so a short frame is never taken as a command
  always_ff @(posedge SCLK) begin
    if (!CS_N && bit_cnt_ff == 5'(`DPSE_WORD_BITS - 1)) begin
      cmd_word_ff  <= {rx_sh_ff, SERIAL_IN};
      word_done_ff <= 1'b1;
    end else if (!CS_N && bit_cnt_ff == 5'h00) begin
      word_done_ff <= 1'b0;
    end
  end

  // first rising edge picks the outgoing word: a pending read reply, or the
  // previous command so that chained devices see it pass through.
  // safe without a synchroniser: the main side settles long before the next
  // frame because the host keeps its wait after every read.
  always_ff @(posedge SCLK) begin
    if (!CS_N && bit_cnt_ff == 5'h00) begin
      if (rd_valid_ff) begin
        tx_word_ff <= {`DPSE_READ_PAD, rd_word_ff};
      end else begin
        tx_word_ff <= cmd_word_ff;
      end
    end
  end

  assign tx_idx = 5'(`DPSE_WORD_BITS) - bit_cnt_ff;

  // output changes on falling edges only, and clears when chip select goes high
  always_ff @(negedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      sdo_ff <= 1'b0;
    end else if (bit_cnt_ff != 5'h00) begin
      sdo_ff <= tx_word_ff[tx_idx];
    end
  end

  assign SERIAL_OUT    = sdo_ff;
  assign SERIAL_OUT_OE = ~CS_N;

  // ---------------------------------------------------------------------------
  // crossings into the main clock
  // ---------------------------------------------------------------------------
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic cs_s3_ff;
  logic wp_s1_ff;
  logic wp_n_s2_ff;
  logic cmd_evt;

  // chip select and write protect pin each pass two flops first; select
  // resets to its idle level so that no false frame end follows reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cs_s1_ff   <= 1'b1;
      cs_s2_ff   <= 1'b1;
      cs_s3_ff   <= 1'b1;
      wp_s1_ff   <= 1'b0;
      wp_n_s2_ff <= 1'b0;
    end else begin
      cs_s1_ff   <= CS_N;
      cs_s2_ff   <= cs_s1_ff;
      cs_s3_ff   <= cs_s2_ff;
      wp_s1_ff   <= WP_N;
      wp_n_s2_ff <= wp_s1_ff;
    end
  end

  // a frame ends when synchronised select rises; word and done flag are
  // steady then (serial clock parked), so they need no flops of their own
  assign cmd_evt = cs_s2_ff && !cs_s3_ff && word_done_ff;

  // ---------------------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------------------
  dpse_pkg::dpse_opcode_type opcode_field;
  logic [1:0] preset_select;
  logic [1:0] channel_select;
  logic       cmd_buf_mode;
  logic [7:0] cmd_data;
  logic       chan_ok;
  logic       wp_open;

  assign opcode_field   = dpse_pkg::dpse_opcode_type'(
                            cmd_word_ff[`DPSE_OPCODE_HI:`DPSE_OPCODE_LO]);
  assign preset_select  = cmd_word_ff[`DPSE_PSEL_HI:`DPSE_PSEL_LO];
  assign channel_select = cmd_word_ff[`DPSE_CHAN_HI:`DPSE_CHAN_LO];
  assign cmd_buf_mode   = cmd_word_ff[`DPSE_BUF_MODE_POS];
  assign cmd_data       = cmd_word_ff[`DPSE_DATA_HI:`DPSE_DATA_LO];
  // a single channel answers only to channel zero, except a wake while asleep
  assign chan_ok        = (channel_select == `DPSE_CHAN_ONLY);
  assign wp_open        = wp_n_s2_ff;

  // ---------------------------------------------------------------------------
  // main state
  // ---------------------------------------------------------------------------
  dpse_pkg::dpse_state_type state_ff;
  dpse_pkg::dpse_state_type nxt_state;
  dpse_pkg::dpse_pend_type  pend_ff;
  logic [16:0] nv_cnt_ff;
  logic        accept;
  logic        nv_cmd;

  // while asleep every command but wake is dropped; while busy, every command is
  assign accept = cmd_evt && (state_ff == dpse_pkg::ST_AWAKE) && chan_ok;

  // commands that start an internal access and make the host wait
  always_comb begin
    case (opcode_field)
      dpse_pkg::OP_RD_WIPER,
      dpse_pkg::OP_RD_PRESET,
      dpse_pkg::OP_PROG,
      dpse_pkg::OP_LOAD,
      dpse_pkg::OP_STORE: nv_cmd = 1'b1;
      default:            nv_cmd = 1'b0;
    endcase
  end

  // state transitions
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dpse_pkg::ST_BOOT: begin
        nxt_state = dpse_pkg::ST_BOOTLD;
      end
      dpse_pkg::ST_BOOTLD: begin
        nxt_state = dpse_pkg::ST_SLEEP;
      end
      dpse_pkg::ST_SLEEP: begin
        if (cmd_evt && opcode_field == dpse_pkg::OP_WAKE) begin
          nxt_state = dpse_pkg::ST_AWAKE;
        end
      end
      dpse_pkg::ST_AWAKE: begin
        if (accept) begin
          case (opcode_field)
            dpse_pkg::OP_SLEEP:   nxt_state = dpse_pkg::ST_SLEEP;
            dpse_pkg::OP_SWRESET: nxt_state = dpse_pkg::ST_BOOT;
            default: begin
              if (nv_cmd) begin
                nxt_state = dpse_pkg::ST_NVWAIT;
              end
            end
          endcase
        end
      end
      dpse_pkg::ST_NVWAIT: begin
        if (nv_cnt_ff == 17'(NV_WAIT_CYC - 1)) begin
          nxt_state = dpse_pkg::ST_AWAKE;
        end
      end
      default: nxt_state = dpse_pkg::ST_BOOT;
    endcase
  end

  // power-up and software reset both start from the boot load
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_ff <= dpse_pkg::ST_BOOT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // save-time counter runs only while busy
  always_ff @(posedge CLK) begin
    if (RESET || state_ff != dpse_pkg::ST_NVWAIT) begin
      nv_cnt_ff <= 17'h00000;
    end else begin
      nv_cnt_ff <= nv_cnt_ff + 17'h00001;
    end
  end

  // ---------------------------------------------------------------------------
  // preset store access
  // ---------------------------------------------------------------------------
  logic [1:0] mem_rd_addr;
  logic [8:0] mem_rd_data;
  logic       mem_wr_en;
  logic [8:0] mem_wr_data;
  logic [7:0] wiper_setting_ff;
  logic       buffer_mode_ff;

  assign mem_rd_addr = (state_ff == dpse_pkg::ST_BOOT) ?
                       `DPSE_BOOT_PRESET : preset_select;

  // writes need an accepted command and an open write protect
  always_comb begin
    mem_wr_en   = 1'b0;
    mem_wr_data = `DPSE_PRESET_ERASED;
    if (accept && wp_open) begin
      case (opcode_field)
        dpse_pkg::OP_PROG: begin
          mem_wr_en   = 1'b1;
          mem_wr_data = {cmd_buf_mode, cmd_data};
        end
        dpse_pkg::OP_STORE: begin
          mem_wr_en   = 1'b1;
          mem_wr_data = {buffer_mode_ff, wiper_setting_ff};
        end
        dpse_pkg::OP_ERASE: begin
          mem_wr_en   = 1'b1;
          mem_wr_data = `DPSE_PRESET_ERASED;
        end
        default: begin
          mem_wr_en   = 1'b0;
          mem_wr_data = `DPSE_PRESET_ERASED;
        end
      endcase
    end
  end

  dpse_preset_mem u_preset_store (
    .clk     (CLK),
    .reset   (RESET),
    .rd_addr (mem_rd_addr),
    .rd_data (mem_rd_data),
    .wr_en   (mem_wr_en),
    .wr_addr (preset_select),
    .wr_data (mem_wr_data)
  );

  // preset read data arrives one cycle after the address
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pend_ff <= dpse_pkg::PEND_NONE;
    end else if (accept && opcode_field == dpse_pkg::OP_RD_PRESET) begin
      pend_ff <= dpse_pkg::PEND_READ;
    end else if (accept && opcode_field == dpse_pkg::OP_LOAD) begin
      pend_ff <= dpse_pkg::PEND_LOAD;
    end else begin
      pend_ff <= dpse_pkg::PEND_NONE;
    end
  end

  // ---------------------------------------------------------------------------
  // wiper and buffer mode
  // ---------------------------------------------------------------------------
  // opcodes not listed fall through untouched
  always_ff @(posedge CLK) begin
    if (RESET) begin
      wiper_setting_ff <= `DPSE_WIPER_MIN;
    end else if (state_ff == dpse_pkg::ST_BOOTLD) begin
      wiper_setting_ff <= mem_rd_data[7:0];
    end else if (pend_ff == dpse_pkg::PEND_LOAD) begin
      wiper_setting_ff <= mem_rd_data[7:0];
    end else if (accept) begin
      case (opcode_field)
        dpse_pkg::OP_WRITE: wiper_setting_ff <= cmd_data;
        dpse_pkg::OP_UP: begin
          if (wiper_setting_ff != `DPSE_WIPER_MAX) begin
            wiper_setting_ff <= wiper_setting_ff + 8'h01;
          end
        end
        dpse_pkg::OP_DOWN: begin
          if (wiper_setting_ff != `DPSE_WIPER_MIN) begin
            wiper_setting_ff <= wiper_setting_ff - 8'h01;
          end
        end
        default: wiper_setting_ff <= wiper_setting_ff;
      endcase
    end
  end

  // mode follows preset loads only, never direct writes or steps
  always_ff @(posedge CLK) begin
    if (RESET) begin
      buffer_mode_ff <= 1'b0;
    end else if (state_ff == dpse_pkg::ST_BOOTLD ||
                 pend_ff == dpse_pkg::PEND_LOAD) begin
      buffer_mode_ff <= mem_rd_data[`DPSE_BUF_MODE_POS];
    end
  end

  // ---------------------------------------------------------------------------
  // read reply
  // ---------------------------------------------------------------------------
  // any other accepted command except a no-op, or a software reset, retires the reply
  always_ff @(posedge CLK) begin
    if (RESET || state_ff == dpse_pkg::ST_BOOT) begin
      rd_valid_ff <= 1'b0;
      rd_word_ff  <= `DPSE_PRESET_INIT;
    end else if (pend_ff == dpse_pkg::PEND_READ) begin
      rd_valid_ff <= 1'b1;
      rd_word_ff  <= mem_rd_data;
    end else if (accept && opcode_field == dpse_pkg::OP_RD_WIPER) begin
      rd_valid_ff <= 1'b1;
      rd_word_ff  <= {buffer_mode_ff, wiper_setting_ff};
    end else if (accept && opcode_field != dpse_pkg::OP_NOP) begin
      rd_valid_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      LOGIC_CLK_EN <= 1'b0;
      NV_BUSY      <= 1'b0;
    end else begin
      LOGIC_CLK_EN <= (nxt_state == dpse_pkg::ST_AWAKE) ||
                      (nxt_state == dpse_pkg::ST_NVWAIT);
      NV_BUSY      <= (nxt_state == dpse_pkg::ST_NVWAIT);
    end
  end

  assign WIPER_SETTING = wiper_setting_ff;
  assign BUFFER_MODE   = buffer_mode_ff;

endmodule

// file: dpse_engine_sva.sv
// ----------------------------------------------------------------------------
// port checker for the command engine
// ----------------------------------------------------------------------------
module dpse_engine_sva #(
  parameter int NV_WAIT_CYC = 20
) (
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       SCLK,
  input wire logic       CS_N,
  input wire logic       SERIAL_IN,
  input wire logic       WP_N,
  input wire logic       SERIAL_OUT,
  input wire logic       SERIAL_OUT_OE,
  input wire logic [7:0] WIPER_SETTING,
  input wire logic       BUFFER_MODE,
  input wire logic       LOGIC_CLK_EN,
  input wire logic       NV_BUSY
);
  logic [3:0]  quiet_cnt_ff;
  logic [3:0]  nxt_quiet_cnt;
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;

  // cycles since chip select rose; wiper, logic clock enable and busy start must land soon after a frame
  assign nxt_quiet_cnt = (RESET || !CS_N) ? 4'h0 :
                         (quiet_cnt_ff == 4'hF) ? 4'hF : quiet_cnt_ff + 4'h1;
  // length of the current busy period
  assign nxt_busy_cnt = NV_BUSY ? busy_cnt_ff + 32'h1 : 32'h0;
  always_ff @(posedge CLK) begin
    quiet_cnt_ff <= nxt_quiet_cnt;
    busy_cnt_ff  <= nxt_busy_cnt;
  end

  // ----------------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_after_frame;
    quiet_cnt_ff <= 4'h8;
  endsequence
  sequence s_busy_done;
    $fell(NV_BUSY);
  endsequence

  a_oe_follows_cs: assert property (SERIAL_OUT_OE == !CS_N)
    else $error("output enable disagrees with chip select");
  a_out_idle_low: assert property (CS_N |-> !SERIAL_OUT)
    else $error("serial output not low outside a frame");
  a_mode_only_load: assert property (
    $changed(BUFFER_MODE) |-> NV_BUSY || !LOGIC_CLK_EN)
    else $error("buffer mode moved outside a preset load");
  a_wiper_after_frame: assert property (
    $changed(WIPER_SETTING) |-> s_after_frame)
    else $error("wiper changed with no command behind it");
  a_clken_after_frame: assert property (
    $changed(LOGIC_CLK_EN) |-> s_after_frame)
    else $error("sleep state changed with no command behind it");
  a_busy_after_frame: assert property ($rose(NV_BUSY) |-> s_after_frame)
    else $error("busy started with no command behind it");
  a_busy_needs_awake: assert property (NV_BUSY |-> LOGIC_CLK_EN)
    else $error("busy while logic clock gated");
  a_busy_bounded: assert property (
    NV_BUSY |-> busy_cnt_ff < NV_WAIT_CYC + 2)
    else $error("save wait longer than allowed");
  a_busy_full: assert property (
    s_busy_done |-> busy_cnt_ff >= NV_WAIT_CYC - 1)
    else $error("save wait ended early");
endmodule

bind dpse_engine dpse_engine_sva #(.NV_WAIT_CYC(NV_WAIT_CYC)) u_sva (
  .CLK           (CLK),
  .RESET         (RESET),
  .SCLK          (SCLK),
  .CS_N          (CS_N),
  .SERIAL_IN     (SERIAL_IN),
  .WP_N          (WP_N),
  .SERIAL_OUT    (SERIAL_OUT),
  .SERIAL_OUT_OE (SERIAL_OUT_OE),
  .WIPER_SETTING (WIPER_SETTING),
  .BUFFER_MODE   (BUFFER_MODE),
  .LOGIC_CLK_EN  (LOGIC_CLK_EN),
  .NV_BUSY       (NV_BUSY)
);

// file: dpse_host_model.sv
// ----------------------------------------------------------------------------
// host side of the serial link: frames of 24 clocks, 15 ns serial period
// ----------------------------------------------------------------------------
module dpse_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // clock parks low between frames, select idles high
  initial begin
    sclk      = 1'b0;
    cs_n      = 1'b1;
    serial_in = 1'b0;
  end

  // data changes while sclk is low; reply bit taken before the next change
  task automatic xfer(input logic [23:0] word, output logic [23:0] reply);
    cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      #3.75;
      if (i < 23) begin
        reply[i+1] = serial_out;
      end
      serial_in = word[i];
      #3.75 sclk = 1'b1;
      #7.5 sclk = 1'b0;
    end
    #3.75 reply[0] = serial_out;
    cs_n = 1'b1;
    // released line shows the inverse so a stale value is never trusted
    serial_in = ~serial_in;
  endtask
endmodule

// file: dpse_engine_tb_top.sv
module dpse_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NV_CYC = 20;

  logic        clk, reset, sclk, cs_n, serial_in, wp_n;
  logic        serial_out, serial_out_oe, buffer_mode, logic_clk_en, nv_busy;
  logic [7:0]  wiper_setting;
  logic [23:0] rep;
  int          error_cnt;
  int          tests_run;
  logic [3:0]  ign_op [5] = '{4'h0, 4'h5, 4'h6, 4'hE, 4'h4};
  logic [1:0]  ign_ch [5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1};

  dpse_engine #(.NV_WAIT_CYC(NV_CYC)) u_dut (
    .CLK(clk), .RESET(reset), .SCLK(sclk), .CS_N(cs_n),
    .SERIAL_IN(serial_in), .WP_N(wp_n), .SERIAL_OUT(serial_out),
    .SERIAL_OUT_OE(serial_out_oe), .WIPER_SETTING(wiper_setting),
    .BUFFER_MODE(buffer_mode), .LOGIC_CLK_EN(logic_clk_en),
    .NV_BUSY(nv_busy));
  dpse_host_model u_host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
    .serial_out(serial_out));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [23:0] st();
    return {15'h0000, buffer_mode, wiper_setting};
  endfunction

  // one command, then the settle time or the whole save wait
  task automatic cmd(input logic [3:0] op, input logic [1:0] ps,
                     input logic [8:0] d, input logic [1:0] ch = 2'h0);
    int n;
    u_host.xfer({op, ps, ch, 7'h00, d}, rep);
    repeat (8) @(negedge clk);
    n = 0;
    while (nv_busy !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      error_cnt++;
      $display("[FAIL] %0t ns: save wait never ended", $time);
      end_sim();
    end
    repeat (4) @(negedge clk);
  endtask

  // a read is followed by a no-op that carries the reply out
  task automatic rd(input logic [3:0] op, input logic [1:0] ps,
                    input logic [23:0] exp);
    cmd(op, ps, 9'h000);
    cmd(4'h0, 2'h0, 9'h000);
    check(rep, exp);
  endtask

  // ----------------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    wp_n = 1'b1;
    error_cnt = 0;
    tests_run = 0;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
    check(st(), 24'h000080);
    check({23'h0, logic_clk_en}, 24'h000000);
    cmd(4'h4, 2'h0, 9'h033);
    check(st(), 24'h000080);
    $display("test boot done");
    cmd(4'h1, 2'h0, 9'h000);
    check({23'h0, logic_clk_en}, 24'h000001);
    cmd(4'h4, 2'h0, 9'h1FE);
    check(st(), 24'h0000FE);
    cmd(4'h7, 2'h0, 9'h000);
    check(st(), 24'h0000FF);
    cmd(4'h7, 2'h0, 9'h000);
    check(st(), 24'h0000FF);
    cmd(4'h4, 2'h0, 9'h001);
    cmd(4'hF, 2'h0, 9'h000);
    check(st(), 24'h000000);
    cmd(4'hF, 2'h0, 9'h000);
    check(st(), 24'h000000);
    $display("test direct done");
    // no-op, undefined codes and a foreign channel all leave things alone
    for (int i = 0; i < 5; i++) begin
      cmd(ign_op[i], 2'h0, 9'h0AA, ign_ch[i]);
      check(st(), 24'h000000);
    end
    $display("test ignored done");
    cmd(4'hD, 2'h2, 9'h000);
    check(rep, 24'h4100AA);
    rd(4'hA, 2'h2, 24'h0001FF);
    cmd(4'h2, 2'h2, 9'h15A);
    rd(4'hA, 2'h2, 24'h00015A);
    check(st(), 24'h000000);
    cmd(4'hB, 2'h2, 9'h000);
    check(st(), 24'h00015A);
    cmd(4'h7, 2'h0, 9'h000);
    check(st(), 24'h00015B);
    rd(4'hC, 2'h0, 24'h00015B);
    cmd(4'hD, 2'h1, 9'h000);
    cmd(4'h3, 2'h1, 9'h000);
    rd(4'hA, 2'h1, 24'h00015B);
    $display("test presets done");
    wp_n = 1'b0;
    repeat (4) @(negedge clk);
    cmd(4'h4, 2'h0, 9'h022);
    cmd(4'hD, 2'h1, 9'h000);
    cmd(4'h2, 2'h1, 9'h011);
    cmd(4'h3, 2'h1, 9'h000);
    rd(4'hA, 2'h1, 24'h00015B);
    cmd(4'hB, 2'h1, 9'h000);
    check(st(), 24'h00015B);
    wp_n = 1'b1;
    repeat (4) @(negedge clk);
    $display("test protect done");
    cmd(4'h8, 2'h0, 9'h000);
    check({23'h0, logic_clk_en}, 24'h000000);
    cmd(4'h4, 2'h0, 9'h044);
    check(st(), 24'h00015B);
    cmd(4'h1, 2'h0, 9'h000);
    cmd(4'h7, 2'h0, 9'h000);
    check(st(), 24'h00015C);
    $display("test sleep done");
    cmd(4'hD, 2'h0, 9'h000);
    cmd(4'h2, 2'h0, 9'h1C3);
    cmd(4'h9, 2'h0, 9'h000);
    check(st(), 24'h0001C3);
    check({23'h0, logic_clk_en}, 24'h000000);
    cmd(4'h1, 2'h0, 9'h000);
    rd(4'hA, 2'h2, 24'h00015A);
    $display("test soft reset done");
    end_sim();
  end
endmodule
